// *** hw/wwds_pkg.sv ***
`default_nettype none
package wwds_pkg;
  // Startup delay and watchdog period in oscillator ticks; the tick rate
  // stands for the resistor-tuned RC oscillator.
  localparam int unsigned OSC_PERIOD_NS   = 1000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned OSC_DIV_CYC     = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_TICKS   = 64;
  localparam int unsigned WD_PERIOD_TICKS = 300;
  localparam int unsigned SLEEP_TICKS     = 900;
  localparam int unsigned CLEARS_TO_EN    = 3;
  localparam int unsigned OPEN_PCT_LOW    = 33;
  localparam int unsigned OPEN_PCT_HIGH   = 67;
  localparam int unsigned PCT_FULL        = 100;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned DIV_W           = 8;
  localparam int unsigned GOOD_W          = 2;

  typedef enum logic [2:0] {WWDS_OFF, WWDS_STARTUP, WWDS_CLOSED, WWDS_OPEN,
                            WWDS_SLEEP} wwds_state_e;

  typedef struct packed {
    logic sys_rst_n;
    logic en_n;
  } wwds_out_s;
endpackage : wwds_pkg
`default_nettype wire

// *** hw/wwds_osc_div.sv ***
`default_nettype none
module wwds_osc_div
  import wwds_pkg::*;
#(
  parameter int unsigned DIV_CYC = OSC_DIV_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Tick
  output var  logic tick
);
  if (DIV_CYC < 1 || DIV_CYC > 255) begin : g_bad_div
    $error("wwds_osc_div: bad DIV_CYC");
  end
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } wwds_div_s;
  wwds_div_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == DIV_W'(DIV_CYC - 1)) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tick = st_r.tick;
endmodule : wwds_osc_div
`default_nettype wire

// *** hw/wwds_edge.sv ***
`default_nettype none
module wwds_edge
  import wwds_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Clear pin, falling edge is a service pulse
  input  wire logic wd_clear_in,
  output var  logic fall
);
  typedef struct packed {
    logic prev;
  } wwds_edge_s;
  wwds_edge_s st_r, st_nxt;
  always_comb begin
    st_nxt.prev = wd_clear_in;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign fall = st_r.prev & ~wd_clear_in;
endmodule : wwds_edge
`default_nettype wire

// *** hw/wwds_top.sv ***
`default_nettype none
module wwds_top
  import wwds_pkg::*;
#(
  parameter int unsigned OPEN_PCT      = OPEN_PCT_LOW,
  parameter bit          SLEEP_VARIANT = 1'b0,
  parameter int unsigned STARTUP_T     = STARTUP_TICKS,
  parameter int unsigned PERIOD_T      = WD_PERIOD_TICKS,
  parameter int unsigned SLEEP_T       = SLEEP_TICKS
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Comparator and clear pin
  input  wire logic sense_in,
  input  wire logic wd_clear_in,
  // Outputs
  output var  logic sys_rst_n_o,
  output var  logic sys_rst_oe,
  output var  logic en_n,
  output var  logic sleep_o
);
  localparam int unsigned CLOSED_T = PERIOD_T * (PCT_FULL - OPEN_PCT) / PCT_FULL;
  localparam int unsigned OPEN_T   = PERIOD_T - CLOSED_T;

  // Refused at elaboration: an open share other than 33 or 67, or a zero count that would underflow the terminal decode
  if (OPEN_PCT != OPEN_PCT_LOW && OPEN_PCT != OPEN_PCT_HIGH) begin : g_bad_pct
    $error("wwds_top: OPEN_PCT must be 33 or 67");
  end
  if (PERIOD_T < 3 || PERIOD_T > 65535 || STARTUP_T < 1 || STARTUP_T > 65535
      || SLEEP_T < 1 || SLEEP_T > 65535 || CLOSED_T < 1 || OPEN_T < 1) begin : g_bad_cnt
    $error("wwds_top: counts out of range");
  end

  logic tick;
  logic clr_fall;

  wwds_osc_div u_div (
    .mclk (mclk),
    .rst_n(rst_n),
    .tick (tick)
  );

  wwds_edge u_edge (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .wd_clear_in(wd_clear_in),
    .fall       (clr_fall)
  );

  typedef struct packed {
    wwds_state_e      state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] idle;
    logic [GOOD_W-1:0] good;
    logic             rst_drv;
    logic             en_n;
    logic             sleep;
  } wwds_st_s;

  wwds_st_s st_r, st_nxt;

  // Common entry to the startup delay, used by every reset cause
  function automatic wwds_st_s restart(input wwds_st_s s);
    wwds_st_s r;
    r = s;
    r.state   = WWDS_STARTUP;
    r.cnt     = '0;
    r.idle    = '0;
    r.good    = '0;
    r.rst_drv = 1'b1;
    r.en_n    = 1'b1;
    r.sleep   = 1'b0;
    return r;
  endfunction

  // Terminal-count decode shared by every timer stage
  function automatic logic at_last(input logic [CNT_W-1:0] c, input int unsigned n);
    return c == CNT_W'(n - 1);
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (!sense_in) begin
      st_nxt = restart(st_r);
      st_nxt.state = WWDS_OFF;
    end else begin
      case (st_r.state)
        WWDS_OFF: begin
          st_nxt = restart(st_r);
        end
        WWDS_STARTUP: begin
          if (tick) begin
            if (at_last(st_r.cnt, STARTUP_T)) begin
              st_nxt.state   = WWDS_CLOSED;
              st_nxt.cnt     = '0;
              st_nxt.rst_drv = 1'b0;
            end else begin
              st_nxt.cnt = st_r.cnt + 16'h0001;
            end
          end
        end
        WWDS_CLOSED: begin
          if (clr_fall) begin
            st_nxt = restart(st_r);
          end else if (tick) begin
            if (at_last(st_r.cnt, CLOSED_T)) begin
              st_nxt.state = WWDS_OPEN;
              st_nxt.cnt   = '0;
            end else begin
              st_nxt.cnt = st_r.cnt + 16'h0001;
            end
          end
        end
        WWDS_OPEN: begin
          if (clr_fall) begin
            st_nxt.state = WWDS_CLOSED;
            st_nxt.cnt   = '0;
            st_nxt.idle  = '0;
            if (st_r.good == GOOD_W'(CLEARS_TO_EN - 1)) begin
              st_nxt.en_n = 1'b0;
            end else begin
              st_nxt.good = st_r.good + 2'h1;
            end
          end else if (tick) begin
            if (SLEEP_VARIANT && at_last(st_r.idle, SLEEP_T)) begin
              st_nxt.state   = WWDS_SLEEP;
              st_nxt.sleep   = 1'b1;
              st_nxt.en_n    = 1'b1;
              st_nxt.good    = '0;
            end else if (at_last(st_r.cnt, OPEN_T)) begin
              if (SLEEP_VARIANT) begin
                // Silent line counts toward sleep, not a fault
                st_nxt.state = WWDS_CLOSED;
                st_nxt.cnt   = '0;
                st_nxt.idle  = st_r.idle + 16'h0001;
                st_nxt.en_n  = 1'b1;
                st_nxt.good  = '0;
              end else begin
                st_nxt = restart(st_r);
              end
            end else begin
              st_nxt.cnt  = st_r.cnt + 16'h0001;
              st_nxt.idle = st_r.idle + 16'h0001;
            end
          end
        end
        WWDS_SLEEP: begin
          if (clr_fall) begin
            st_nxt = restart(st_r);
          end
        end
        default: begin
          st_nxt = restart(st_r);
        end
      endcase
      if (SLEEP_VARIANT && st_r.state == WWDS_CLOSED && tick && !clr_fall) begin
        st_nxt.idle = st_r.idle + 16'h0001;
        if (at_last(st_r.idle, SLEEP_T)) begin
          st_nxt.state = WWDS_SLEEP;
          st_nxt.sleep = 1'b1;
          // Standby never leaves critical functions enabled
          st_nxt.en_n  = 1'b1;
          st_nxt.good  = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: WWDS_OFF, cnt: '0, idle: '0, good: '0,
                rst_drv: 1'b1, en_n: 1'b1, sleep: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain: pin only ever pulled low
  assign sys_rst_n_o = 1'b0;
  assign sys_rst_oe  = st_r.rst_drv;
  assign en_n        = st_r.en_n;
  assign sleep_o     = st_r.sleep;

  a_low_sense_rst: assert property (@(posedge mclk) disable iff (!rst_n)
    !sense_in |=> sys_rst_oe && en_n)
    else $error("reset not driven with sense low");

  a_closed_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_CLOSED && clr_fall |=> sys_rst_oe && en_n)
    else $error("closed clear did not reset");

  sequence s_open_clear;
    sense_in && st_r.state == WWDS_OPEN && clr_fall;
  endsequence
  a_open_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    s_open_clear |=> st_r.state == WWDS_CLOSED && st_r.cnt == 16'h0000 && !sys_rst_oe)
    else $error("good clear did not restart period");

  a_en_count: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(en_n) |-> $past(st_r.good) == 2'h2 && $past(clr_fall))
    else $error("enable without three clears");

  a_startup_rel: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(sys_rst_oe) |-> $past(st_r.state) == WWDS_STARTUP
      && $past(st_r.cnt) == CNT_W'(STARTUP_T - 1) && $past(tick))
    else $error("reset released early");

  a_rst_en_off: assert property (@(posedge mclk) disable iff (!rst_n)
    sys_rst_oe |-> en_n && st_r.good == 2'h0)
    else $error("enable active during reset");

  a_late_rst: assert property (@(posedge mclk) disable iff (!rst_n)
    !SLEEP_VARIANT && sense_in && st_r.state == WWDS_OPEN && tick && !clr_fall
      && st_r.cnt == CNT_W'(OPEN_T - 1) |=> sys_rst_oe)
    else $error("missed clear did not reset");

  a_od_level: assert property (@(posedge mclk) disable iff (!rst_n)
    sys_rst_n_o == 1'b0 && (sys_rst_oe || (st_r.state != WWDS_OFF
      && st_r.state != WWDS_STARTUP)))
    else $error("reset line released too soon");

  a_sleep_off: assert property (@(posedge mclk) disable iff (!rst_n)
    sleep_o |-> SLEEP_VARIANT && en_n && st_r.state == WWDS_SLEEP)
    else $error("bad sleep state");

  // Window stage ends and the third good clear, built into the checks below
  sequence s_closed_end;
    sense_in && st_r.state == WWDS_CLOSED && tick && !clr_fall
      && st_r.cnt == CNT_W'(CLOSED_T - 1);
  endsequence

  sequence s_third_clear;
    s_open_clear ##0 st_r.good == GOOD_W'(CLEARS_TO_EN - 1);
  endsequence

  sequence s_open_end;
    sense_in && st_r.state == WWDS_OPEN && tick && !clr_fall
      && st_r.cnt == CNT_W'(OPEN_T - 1);
  endsequence

  a_off_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.state == WWDS_OFF |-> sys_rst_oe && en_n)
    else $error("reset released while off");

  a_off_start: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_OFF |=> st_r.state == WWDS_STARTUP
      && st_r.cnt == 16'h0000)
    else $error("startup delay not begun");

  a_startup_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.state == WWDS_STARTUP |-> sys_rst_oe && !sleep_o)
    else $error("reset released during startup");

  a_startup_tick: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_STARTUP && !tick
      |=> st_r.state == WWDS_STARTUP && $stable(st_r.cnt))
    else $error("startup counted without a tick");

  a_closed_tick: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_CLOSED && !tick && !clr_fall
      |=> st_r.state == WWDS_CLOSED && $stable(st_r.cnt))
    else $error("closed part counted without a tick");

  a_window_open: assert property (@(posedge mclk) disable iff (!rst_n)
    s_closed_end |=> st_r.cnt == 16'h0000
      && (st_r.state == WWDS_OPEN || st_r.state == WWDS_SLEEP))
    else $error("closed part did not end on time");

  a_open_released: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.state == WWDS_OPEN |-> !sys_rst_oe)
    else $error("reset held in open part");

  a_third_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    s_third_clear |=> !en_n)
    else $error("third clear did not enable");

  a_en_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !en_n && sense_in && !tick && !clr_fall |=> !en_n)
    else $error("enable dropped without cause");

  a_miss_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    s_open_end |=> en_n && st_r.good == 2'h0)
    else $error("missed clear kept enable");

  a_sleep_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_SLEEP && !clr_fall |=> sleep_o && !sys_rst_oe)
    else $error("standby left without a clear");

  a_sleep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_in && st_r.state == WWDS_SLEEP && clr_fall |=> sys_rst_oe && !sleep_o)
    else $error("clear did not wake from standby");

  a_sleep_only: assert property (@(posedge mclk) disable iff (!rst_n)
    !SLEEP_VARIANT |-> st_r.state != WWDS_SLEEP)
    else $error("standby in a variant without it");
endmodule : wwds_top
`default_nettype wire

// *** testbench/wwds_mcu_model.sv ***
`default_nettype none
module wwds_mcu_model (
  // Clock
  input  wire logic mclk,
  // Clear pin
  output var  logic wd_clear_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial wd_clear_in = 1'b1;

  // Held low three cycles so any edge sampler sees it
  task automatic pulse();
    @(negedge mclk);
    wd_clear_in = 1'b0;
    repeat (3) @(negedge mclk);
    wd_clear_in = 1'b1;
  endtask
endmodule // wwds_mcu_model
`default_nettype wire

// *** testbench/windowed_watchdog_supervisor_tb.sv ***
`default_nettype none
module windowed_watchdog_supervisor_tb import wwds_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST  = 4;
  localparam int PT  = 9;
  localparam int SLT = 20;
  localparam int TK  = OSC_DIV_CYC;
  localparam int CT  = PT * (PCT_FULL - OPEN_PCT_LOW) / PCT_FULL;
  logic mclk     = 1'b0;
  logic rst_n    = 1'b0;
  logic sense_in = 1'b0;
  logic wd_clear_in, oe, rst_o, en_n, slp, oe2, en2_n, slp2, oe3, en3_n;
  int   mismatches = 0;
  int   n_tests    = 0;
  int   cyc        = 0;
  int   good       = 0;
  int   n;
  int   seed       = 32'hD2501C20;

  always #5 mclk = ~mclk;

  wwds_top #(.STARTUP_T(ST), .PERIOD_T(PT), .SLEEP_T(SLT)) u_wwds_top (
    .mclk(mclk), .rst_n(rst_n), .sense_in(sense_in), .wd_clear_in(wd_clear_in),
    .sys_rst_n_o(rst_o), .sys_rst_oe(oe), .en_n(en_n), .sleep_o(slp));
  wwds_top #(.SLEEP_VARIANT(1'b1), .STARTUP_T(ST), .PERIOD_T(PT), .SLEEP_T(SLT))
    u_wwds_top_slp (
    .mclk(mclk), .rst_n(rst_n), .sense_in(sense_in), .wd_clear_in(wd_clear_in),
    .sys_rst_n_o(), .sys_rst_oe(oe2), .en_n(en2_n), .sleep_o(slp2));
  // Wide-open variant: closed part 2 ticks of the 9-tick period
  wwds_top #(.OPEN_PCT(OPEN_PCT_HIGH), .STARTUP_T(ST), .PERIOD_T(PT), .SLEEP_T(SLT))
    u_wwds_top_hi (
    .mclk(mclk), .rst_n(rst_n), .sense_in(sense_in), .wd_clear_in(wd_clear_in),
    .sys_rst_n_o(), .sys_rst_oe(oe3), .en_n(en3_n), .sleep_o());
  wwds_mcu_model u_wwds_mcu_model (.mclk(mclk), .wd_clear_in(wd_clear_in));

  task automatic chk(string nm, logic got, logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Cycles until s reaches lvl, -1 if the bound runs out
  task automatic wait_for(ref logic s, input logic lvl, input int lim, output int c);
    c = 0;
    while (s !== lvl && c < lim) begin
      @(negedge mclk);
      c++;
    end
    if (s !== lvl) c = -1;
  endtask

  // Half a tick into the open part, plus jitter well short of its end
  task automatic good_clear();
    n = {$random(seed)} % 40;
    repeat (CT * TK + TK / 2 + n) @(negedge mclk);
    u_wwds_mcu_model.pulse();
    good++;
    repeat (2) @(negedge mclk);
    chk("oe_good", oe, 1'b0);
    chk("en_n_good", en_n, good < CLEARS_TO_EN);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(negedge mclk);
    chk("oe_rst", oe, 1'b1);
    chk("en_n_rst", en_n, 1'b1);
    chk("sleep_rst", slp2, 1'b0);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk("od_data", rst_o, 1'b0);
    sense_in = 1'b1;
    wait_for(oe, 1'b0, (ST + 2) * TK, n);
    chk("por_done", n >= 0, 1'b1);
    chk("por_min", n >= (ST - 1) * TK, 1'b1);
    for (int i = 0; i < 3; i++) good_clear();
    // Clear half a tick before the closed part can have ended
    repeat (CT * TK - 3 * TK / 2) @(negedge mclk);
    u_wwds_mcu_model.pulse();
    good = 0;
    chk("early_oe", oe, 1'b1);
    chk("early_en_n", en_n, 1'b1);
    // Same clear lands past the short closed part of the wide-open variant
    chk("hi_early_oe", oe3, 1'b0);
    chk("hi_early_en_n", en3_n, 1'b0);
    wait_for(oe, 1'b0, (ST + 2) * TK, n);
    good_clear();
    wait_for(oe, 1'b1, (PT + 2) * TK, n);
    chk("late_oe", n >= (PT - 2) * TK, 1'b1);
    chk("late_en_n", en_n, 1'b1);
    chk("slp_en_n", en2_n, 1'b1);
    wait_for(slp2, 1'b1, (SLT + 2) * TK, n);
    chk("slp_enter", n >= 0, 1'b1);
    chk("slp_en_off", en2_n, 1'b1);
    chk("no_slp_main", slp, 1'b0);
    u_wwds_mcu_model.pulse();
    @(negedge mclk);
    chk("slp_wake", oe2, 1'b1);
    wait_for(oe, 1'b0, (ST + 2) * TK, n);
    chk("pre_brown", n >= 0, 1'b1);
    sense_in = 1'b0;
    repeat (2) @(negedge mclk);
    chk("brown_oe", oe, 1'b1);
    chk("brown_en_n", en_n, 1'b1);
    end_sim();
  end
endmodule // windowed_watchdog_supervisor_tb
`default_nettype wire
